// ### verilog/pio_pkg.sv
// Constants shared by the parallel I/O port and its helper modules.
// Assumes a word-addressed register port with one 32-bit word per offset.
package pio_pkg;

  // Port and register geometry
  localparam int DATA_W = 32;
  localparam int ADDR_W = 3;

  // Register word offsets
  localparam logic [ADDR_W-1:0] OFS_PIN_VALUE = 3'h0;
  localparam logic [ADDR_W-1:0] OFS_LINE_DIRECTION = 3'h1;
  localparam logic [ADDR_W-1:0] OFS_IRQ_ENABLE_MASK = 3'h2;
  localparam logic [ADDR_W-1:0] OFS_EDGE_LATCH = 3'h3;
  localparam logic [ADDR_W-1:0] OFS_OUTPUT_BIT_SET = 3'h4;
  localparam logic [ADDR_W-1:0] OFS_OUTPUT_BIT_CLEAR = 3'h5;

  // Reset values
  localparam logic [DATA_W-1:0] RST_PIN_VALUE = 32'h0000_0000;
  localparam logic [DATA_W-1:0] RST_LINE_DIRECTION = 32'h0000_0000;
  localparam logic [DATA_W-1:0] RST_IRQ_ENABLE_MASK = 32'h0000_0000;
  localparam logic [DATA_W-1:0] RST_EDGE_LATCH = 32'h0000_0000;
  localparam logic [DATA_W-1:0] RST_READ_DATA = 32'h0000_0000;
  localparam logic [DATA_W-1:0] UNMAPPED_READ = 32'h0000_0000;

  // Input filter: enabled cycles before filtered levels are trusted
  localparam int SETTLE_W = 2;
  localparam logic [SETTLE_W-1:0] SETTLE_CYCLES = 2'h3;

endpackage

// ### verilog/pin_sync.sv
// Three-stage synchroniser with agreement filter for the port's input lines.
// Assumes pin levels change asynchronously to sys_clk.
`timescale 1ns/10ps

module pin_sync #(
  parameter int W = 32
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic [W-1:0] pin_async,
  output logic [W-1:0] level,
  output logic level_valid
);
  import pio_pkg::*;

  logic [W-1:0] meta_q;
  logic [W-1:0] sync2_q;
  logic [W-1:0] sync3_q;
  logic [W-1:0] level_q;
  logic [W-1:0] level_d;
  logic [SETTLE_W-1:0] settle_q;
  logic valid_q;

  // First stage feeds only the second stage
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      meta_q <= '0;
      sync2_q <= '0;
      sync3_q <= '0;
    end else if (clk_en) begin
      meta_q <= pin_async;
      sync2_q <= meta_q;
      sync3_q <= sync2_q;
    end
  end

  // A bit moves only where stages two and three agree
  always_comb begin
    level_d = (sync2_q & sync3_q) | (level_q & (sync2_q | sync3_q));
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      level_q <= '0;
    end else if (clk_en) begin
      level_q <= level_d;
    end
  end

  // Blocks false edges while the pipeline still holds reset zeros
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      settle_q <= '0;
      valid_q <= 1'b0;
    end else if (clk_en) begin
      if (settle_q == SETTLE_CYCLES) begin
        valid_q <= 1'b1;
      end else begin
        settle_q <= settle_q + 1'b1;
      end
    end
  end

  assign level = level_q;
  assign level_valid = valid_q;

endmodule

// ### verilog/edge_latch_bits.sv
// Sticky edge detector, one bit per line, cleared by selected-bit writes.
// Assumes filtered, synchronous levels and a one-cycle clear strobe.
`timescale 1ns/10ps

module edge_latch_bits #(
  parameter int W = 32
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic [W-1:0] level,
  input wire logic level_valid,
  input wire logic [W-1:0] capture_en,
  input wire logic clear_we,
  input wire logic [W-1:0] clear_bits,
  output logic [W-1:0] latched
);
  import pio_pkg::*;

  logic [W-1:0] prev_q;
  logic armed_q;
  logic [W-1:0] hit;
  logic [W-1:0] latch_q;
  logic [W-1:0] latch_d;

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      prev_q <= '0;
      armed_q <= 1'b0;
    end else if (clk_en) begin
      prev_q <= level;
      armed_q <= level_valid;
    end
  end

  // Either direction of change counts as an edge
  assign hit = armed_q ? ((level ^ prev_q) & capture_en) : '0;

  // A new edge beats a clear in the same cycle
  always_comb begin
    latch_d = latch_q;
    if (clear_we) begin
      latch_d = latch_d & ~clear_bits;
    end
    latch_d = latch_d | hit;
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      latch_q <= RST_EDGE_LATCH;
    end else if (clk_en) begin
      latch_q <= latch_d;
    end
  end

  assign latched = latch_q;

  a_edge_set_wins: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (clk_en && hit != '0) |=> ((latch_q & $past(hit)) == $past(hit)))
    else $error("Edge lost to a clear in the same cycle");

endmodule

// ### verilog/parallel_io_port_regs.sv
// Parallel I/O port: word registers for pin data, direction, interrupt
// enable, edge capture and set-bit / clear-bit writes.
// Assumes a word-addressed register port on sys_clk and two-way pins
// resolved outside from pin_out and pin_oe.
`timescale 1ns/10ps

module parallel_io_port_regs (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic [pio_pkg::ADDR_W-1:0] reg_addr,
  input wire logic reg_read,
  input wire logic reg_write,
  input wire logic [pio_pkg::DATA_W-1:0] reg_wdata,
  output logic [pio_pkg::DATA_W-1:0] reg_rdata,
  input wire logic [pio_pkg::DATA_W-1:0] pin_in,
  output logic [pio_pkg::DATA_W-1:0] pin_out,
  output logic [pio_pkg::DATA_W-1:0] pin_oe,
  output logic irq
);
  import pio_pkg::*;

  logic [DATA_W-1:0] out_q;
  logic [DATA_W-1:0] out_d;
  logic [DATA_W-1:0] dir_q;
  logic [DATA_W-1:0] mask_q;
  logic [DATA_W-1:0] rdata_q;
  logic [DATA_W-1:0] rdata_d;
  logic [DATA_W-1:0] pin_level;
  logic pin_level_valid;
  logic [DATA_W-1:0] edge_bits;
  logic irq_q;

  logic wr_data;
  logic wr_dir;
  logic wr_mask;
  logic wr_edge;
  logic wr_set;
  logic wr_clear;
  logic rd_take;

  // Access decode; strobes only count while the clock enable is high
  assign wr_data = clk_en && reg_write && (reg_addr == OFS_PIN_VALUE);
  assign wr_dir = clk_en && reg_write && (reg_addr == OFS_LINE_DIRECTION);
  assign wr_mask = clk_en && reg_write && (reg_addr == OFS_IRQ_ENABLE_MASK);
  assign wr_edge = clk_en && reg_write && (reg_addr == OFS_EDGE_LATCH);
  assign wr_set = clk_en && reg_write && (reg_addr == OFS_OUTPUT_BIT_SET);
  assign wr_clear = clk_en && reg_write && (reg_addr == OFS_OUTPUT_BIT_CLEAR);
  assign rd_take = clk_en && reg_read;

  // Input path: pins are asynchronous, so they are filtered first
  pin_sync #(
    .W(DATA_W)
  ) u_pin_sync (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .pin_async(pin_in),
    .level(pin_level),
    .level_valid(pin_level_valid)
  );

  // Only lines set as inputs capture edges
  edge_latch_bits #(
    .W(DATA_W)
  ) u_edge_latch (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .level(pin_level),
    .level_valid(pin_level_valid),
    .capture_en(~dir_q),
    .clear_we(wr_edge),
    .clear_bits(reg_wdata),
    .latched(edge_bits)
  );

  // Output data: plain write, set-bit write and clear-bit write share
  // one register, so only one of them can land per cycle
  always_comb begin
    out_d = out_q;
    if (wr_data) begin
      out_d = reg_wdata;
    end else if (wr_set) begin
      out_d = out_q | reg_wdata;
    end else if (wr_clear) begin
      out_d = out_q & ~reg_wdata;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      out_q <= RST_PIN_VALUE;
    end else if (clk_en) begin
      out_q <= out_d;
    end
  end

  // Direction register
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      dir_q <= RST_LINE_DIRECTION;
    end else if (wr_dir) begin
      dir_q <= reg_wdata;
    end
  end

  // Interrupt enable register
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      mask_q <= RST_IRQ_ENABLE_MASK;
    end else if (wr_mask) begin
      mask_q <= reg_wdata;
    end
  end

  // Read mux; write-only and unmapped words read as zero
  always_comb begin
    case (reg_addr)
      OFS_PIN_VALUE: rdata_d = pin_level;
      OFS_LINE_DIRECTION: rdata_d = dir_q;
      OFS_IRQ_ENABLE_MASK: rdata_d = mask_q;
      OFS_EDGE_LATCH: rdata_d = edge_bits;
      default: rdata_d = UNMAPPED_READ;
    endcase
  end

  // Read data holds until the next read is taken
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_q <= RST_READ_DATA;
    end else if (rd_take) begin
      rdata_q <= rdata_d;
    end
  end

  // Registered so the request never glitches on decode
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_q <= 1'b0;
    end else if (clk_en) begin
      irq_q <= |(edge_bits & mask_q);
    end
  end

  // Lamps on the low bits are active low; the port itself stays
  // polarity-neutral and drives exactly what software wrote
  assign pin_out = out_q;
  assign pin_oe = dir_q;
  assign reg_rdata = rdata_q;
  assign irq = irq_q;

  default clocking cb @(posedge sys_clk);
  endclocking

  default disable iff (sys_rst);

  sequence s_dir_written;
    wr_dir;
  endsequence

  sequence s_dir_read_back;
    clk_en && reg_read && reg_addr == OFS_LINE_DIRECTION && !reg_write;
  endsequence

  sequence s_edge_seen;
    clk_en && edge_bits != '0 && !wr_edge;
  endsequence

  sequence s_mask_written;
    wr_mask;
  endsequence

  sequence s_mask_read_back;
    clk_en && reg_read && reg_addr == OFS_IRQ_ENABLE_MASK && !reg_write;
  endsequence

  a_data_write: assert property (
    wr_data |=> pin_out == $past(reg_wdata))
    else $error("Data write not driven on outputs");

  a_set_bits: assert property (
    wr_set |=> pin_out == ($past(pin_out) | $past(reg_wdata)))
    else $error("Set-bit write changed wrong bits");

  a_clear_bits: assert property (
    wr_clear |=> pin_out == ($past(pin_out) & ~$past(reg_wdata)))
    else $error("Clear-bit write changed wrong bits");

  a_output_hold: assert property (
    !(reg_write && clk_en) |=> $stable(pin_out))
    else $error("Outputs changed without a write");

  a_dir_to_oe: assert property (
    s_dir_written |=> pin_oe == $past(reg_wdata))
    else $error("Direction write not reflected on enables");

  a_dir_readback: assert property (
    s_dir_written ##1 s_dir_read_back |=> reg_rdata == $past(pin_oe))
    else $error("Direction read back differs from enables");

  a_mask_write: assert property (
    wr_mask ##1 (clk_en && reg_read && reg_addr == OFS_IRQ_ENABLE_MASK && !reg_write)
      |=> reg_rdata == $past(reg_wdata, 2))
    else $error("Interrupt enable read back wrong");

  a_pin_read: assert property (
    (rd_take && reg_addr == OFS_PIN_VALUE) |=> reg_rdata == $past(pin_level))
    else $error("Pin read does not return input levels");

  a_edge_sticky: assert property (
    s_edge_seen |=> (($past(edge_bits) & ~edge_bits) == '0))
    else $error("Edge bit dropped without a clear");

  a_edge_clear: assert property (
    wr_edge |=> (edge_bits & $past(reg_wdata)
      & ~($past(pin_level) ^ $past(pin_level, 2))) == '0)
    else $error("Edge clear write left old bits set");

  a_irq_cause: assert property (
    (clk_en && (edge_bits & mask_q) != '0) |=> irq)
    else $error("Interrupt not raised for enabled edge");

  a_irq_masked: assert property (
    (wr_mask && reg_wdata == '0) ##1 clk_en |=> !irq)
    else $error("Interrupt raised with all enables clear");

  a_unmapped_zero: assert property (
    (rd_take && reg_addr > OFS_EDGE_LATCH) |=> reg_rdata == '0)
    else $error("Write-only or unmapped word read nonzero");

  a_freeze: assert property (
    !clk_en |=> $stable(pin_out) && $stable(pin_oe) && $stable(reg_rdata) && $stable(irq))
    else $error("State moved while clock enable low");

  // Registers move only on their own taken write
  a_dir_hold: assert property (
    !wr_dir |=> $stable(pin_oe))
    else $error("Enables changed without a direction write");

  a_mask_hold: assert property (
    !wr_mask |=> $stable(mask_q))
    else $error("Interrupt enables changed without a write");

  a_out_other_words: assert property (
    (wr_dir || wr_mask || wr_edge) |=> $stable(pin_out))
    else $error("Outputs changed on a write to another word");

  a_ignored_words: assert property (
    (clk_en && reg_write && reg_addr > OFS_OUTPUT_BIT_CLEAR)
      |=> $stable(pin_out) && $stable(pin_oe) && $stable(mask_q))
    else $error("Write to an unmapped word changed a register");

  // Read data is only refreshed by a taken read
  a_rdata_hold: assert property (
    !rd_take |=> $stable(reg_rdata))
    else $error("Read data changed without a read");

  a_dir_read: assert property (
    (rd_take && reg_addr == OFS_LINE_DIRECTION) |=> reg_rdata == $past(dir_q))
    else $error("Direction read returned wrong word");

  a_mask_read: assert property (
    (rd_take && reg_addr == OFS_IRQ_ENABLE_MASK) |=> reg_rdata == $past(mask_q))
    else $error("Interrupt enable read returned wrong word");

  a_mask_readback: assert property (
    s_mask_written ##1 s_mask_read_back |=> reg_rdata == $past(mask_q))
    else $error("Interrupt enable read back after write differs");

  a_edge_read: assert property (
    (rd_take && reg_addr == OFS_EDGE_LATCH) |=> reg_rdata == $past(edge_bits))
    else $error("Edge read returned wrong word");

  // Output lines never capture, and nothing captures while settling
  a_edge_inputs_only: assert property (
    clk_en |=> ((edge_bits & ~$past(edge_bits)) & $past(dir_q)) == '0)
    else $error("Edge captured on an output line");

  a_edge_settle: assert property (
    !pin_level_valid |-> edge_bits == '0)
    else $error("Edge captured before inputs settled");

  a_edge_write_keeps: assert property (
    wr_edge |=> ($past(edge_bits) & ~$past(reg_wdata) & ~edge_bits) == '0)
    else $error("Edge bit written zero was dropped");

  a_irq_source: assert property (
    (clk_en && (edge_bits & mask_q) == '0) |=> !irq)
    else $error("Interrupt raised without an enabled edge");

endmodule

// ### test/pin_far_end.sv
// Far side of the port: the pin wires and two active-low lamps.
// Assumes the bench supplies the level on lines the port does not drive.
`timescale 1ns/10ps
module pin_far_end (
  input wire logic [31:0] pin_out,
  input wire logic [31:0] pin_oe,
  input wire logic [31:0] ext_level,
  output logic [31:0] pin_level,
  output logic [1:0] lamp_lit
);
  // Driven lines show the port's value, the rest the outside level
  assign pin_level = (pin_out & pin_oe) | (ext_level & ~pin_oe);
  assign lamp_lit = ~pin_level[1:0];
endmodule

// ### test/parallel_io_port_regs_tb.sv
// Self-checking bench for the parallel I/O port registers.
// Assumes one 100 MHz clock and the pin far-end model.
`timescale 1ns/10ps
module parallel_io_port_regs_tb;
  import pio_pkg::*;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic clk_en = 1'b1;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic reg_read = 1'b0;
  logic reg_write = 1'b0;
  logic [DATA_W-1:0] reg_wdata = '0;
  logic [DATA_W-1:0] ext_level = '0;
  logic [DATA_W-1:0] reg_rdata, pin_out, pin_oe, pin_level, rd_q, outs_q, d, m;
  logic irq;
  logic [1:0] lamp_lit;
  int fails = 0;
  int checks = 0;
  int k;
  int b;
  int c;

  always #5 sys_clk = ~sys_clk;

  parallel_io_port_regs u_parallel_io_port_regs (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .clk_en(clk_en), .reg_addr(reg_addr),
    .reg_read(reg_read), .reg_write(reg_write), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .pin_in(pin_level), .pin_out(pin_out), .pin_oe(pin_oe),
    .irq(irq)
  );
  pin_far_end u_pin_far_end (
    .pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext_level),
    .pin_level(pin_level), .lamp_lit(lamp_lit)
  );

  function automatic logic [DATA_W-1:0] f_wire(input logic [DATA_W-1:0] o,
      input logic [DATA_W-1:0] oe, input logic [DATA_W-1:0] e);
    return (o & oe) | (e & ~oe);
  endfunction

  task automatic end_of_test;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t word %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t flag %b expected %b", $time, got, exp);
    end
  endtask

  // One idle cycle after each strobe so no signal is set twice per step
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
    reg_addr = a;
    reg_wdata = v;
    reg_write = 1'b1;
    @(posedge sys_clk);
    #1 reg_write = 1'b0;
    @(posedge sys_clk);
    #1;
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a);
    reg_addr = a;
    reg_read = 1'b1;
    @(posedge sys_clk);
    #1 rd_q = reg_rdata;
    reg_read = 1'b0;
    @(posedge sys_clk);
    #1;
  endtask

  // Write, then read the same word on the very next edge
  task automatic wr_rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
    reg_addr = a;
    reg_wdata = v;
    reg_write = 1'b1;
    @(posedge sys_clk);
    #1 reg_write = 1'b0;
    reg_read = 1'b1;
    @(posedge sys_clk);
    #1 rd_q = reg_rdata;
    reg_read = 1'b0;
    @(posedge sys_clk);
    #1;
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic wait_irq(input logic exp);
    int n;
    n = 0;
    while (irq !== exp && n < 20) begin
      @(posedge sys_clk);
      #1 n++;
    end
    chk_bit(irq, exp);
    if (irq !== exp) begin
      end_of_test();
    end
  endtask

  initial begin
    void'($urandom(32'h3212));
    repeat (4) @(posedge sys_clk);
    #1 sys_rst = 1'b0;
    chk(pin_out, RST_PIN_VALUE);
    chk(pin_oe, RST_LINE_DIRECTION);
    chk_bit(irq, 1'b0);
    for (k = 1; k < 8; k++) begin
      rd(k[ADDR_W-1:0]);
      chk(rd_q, 32'h0000_0000);
    end
    wr(3'h7, 32'hffff_ffff);
    chk(pin_out | pin_oe, 32'h0000_0000);
    $display("test reset done");

    wr(OFS_LINE_DIRECTION, 32'h0000_0003);
    wr(OFS_PIN_VALUE, 32'h0000_0003);
    chk(pin_out, 32'h0000_0003);
    chk({30'h0, lamp_lit}, 32'h0000_0000);
    wr(OFS_PIN_VALUE, 32'h0000_0000);
    chk({30'h0, lamp_lit}, 32'h0000_0003);
    $display("test lamps done");

    for (k = 0; k < 4; k++) begin
      d = $urandom();
      wr_rd(OFS_LINE_DIRECTION, d);
      chk(rd_q, d);
      chk(pin_oe, d);
      wr_rd(OFS_IRQ_ENABLE_MASK, ~d);
      chk(rd_q, ~d);
    end
    $display("test direction and mask done");

    outs_q = $urandom();
    wr(OFS_PIN_VALUE, outs_q);
    for (k = 0; k < 10; k++) begin
      // First two passes hit the all-ones corner
      // Direction stays in d for the pin read below
      m = (k < 2) ? 32'hffff_ffff : $urandom();
      if (k % 2 == 1) begin
        wr(OFS_OUTPUT_BIT_CLEAR, m);
        outs_q = outs_q & ~m;
      end else begin
        wr(OFS_OUTPUT_BIT_SET, m);
        outs_q = outs_q | m;
      end
      chk(pin_out, outs_q);
    end
    $display("test set and clear done");

    ext_level = $urandom();
    idle(8);
    rd(OFS_PIN_VALUE);
    chk(rd_q, f_wire(outs_q, d, ext_level));
    $display("test pin read done");

    wr(OFS_IRQ_ENABLE_MASK, 32'h0000_0000);
    wr(OFS_LINE_DIRECTION, 32'h0000_0000);
    ext_level = 32'h0000_0000;
    idle(8);
    wr(OFS_EDGE_LATCH, 32'hffff_ffff);
    wait_irq(1'b0);
    rd(OFS_EDGE_LATCH);
    chk(rd_q, 32'h0000_0000);
    b = $urandom_range(31, 0);
    c = (b + 1) % 32;
    m = 32'h1 << b;
    wr(OFS_IRQ_ENABLE_MASK, m);
    ext_level = m | (32'h1 << c);
    wait_irq(1'b1);
    rd(OFS_EDGE_LATCH);
    chk(rd_q, ext_level);
    wr(OFS_EDGE_LATCH, 32'h0000_0000);
    rd(OFS_EDGE_LATCH);
    chk(rd_q, ext_level);
    wr(OFS_EDGE_LATCH, 32'h1 << c);
    idle(3);
    chk_bit(irq, 1'b1);
    wr(OFS_EDGE_LATCH, m);
    wait_irq(1'b0);
    rd(OFS_EDGE_LATCH);
    chk(rd_q, 32'h0000_0000);
    ext_level = 32'h0000_0000;
    wait_irq(1'b1);
    wr(OFS_IRQ_ENABLE_MASK, 32'h0000_0000);
    wait_irq(1'b0);
    rd(OFS_EDGE_LATCH);
    chk(rd_q, m | (32'h1 << c));
    $display("test edges done");

    // Frozen enable: strobes are dropped and every register holds
    clk_en = 1'b0;
    wr(OFS_PIN_VALUE, ~outs_q);
    wr(OFS_LINE_DIRECTION, 32'hffff_ffff);
    rd(OFS_LINE_DIRECTION);
    chk(pin_out, outs_q);
    chk(pin_oe, 32'h0000_0000);
    chk(rd_q, m | (32'h1 << c));
    clk_en = 1'b1;
    wr(OFS_PIN_VALUE, ~outs_q);
    chk(pin_out, ~outs_q);
    $display("test clock enable done");
    end_of_test();
  end
endmodule
